// ---- common/bau_map.svh ----
// register map, field positions and reset values of the byte arithmetic unit
`ifndef BAU_MAP_SVH
`define BAU_MAP_SVH

// ****************************************************************
// bus geometry and byte offsets
// ****************************************************************
`define BAU_ADDR_W 8
`define BAU_OFF_ACCUM 8'h00
`define BAU_OFF_FLAGS 8'h04
`define BAU_OFF_CMD 8'h08
`define BAU_OFF_MEM 8'h40

// ****************************************************************
// flag bit positions
// ****************************************************************
`define BAU_FLAG_Z 0
`define BAU_FLAG_C 1
`define BAU_FLAG_AUX 2
`define BAU_FLAG_OVF 3

// ****************************************************************
// command fields (low bit of each)
// ****************************************************************
`define BAU_CMD_OP_LSB 0
`define BAU_CMD_ADDR_LSB 8
`define BAU_CMD_IMM_LSB 16

// ****************************************************************
// reset values and bus answers
// ****************************************************************
`define BAU_RST_ACC 8'h00
`define BAU_RST_FLAGS 4'h0
`define BAU_RST_CMD 24'h000000
`define BAU_RST_MEM 8'h00
`define BAU_RESP_OKAY 2'h0
`define BAU_RESP_SLVERR 2'h2

`endif

// ---- common/bau_pkg.sv ----
// types shared by the byte arithmetic unit
package bau_pkg;

  // ****************************************************************
  // operation codes as software writes them into the command register
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_ADD_AI = 5'h01,
    OP_ADD_AM = 5'h02,
    OP_ADD_MA = 5'h03,
    OP_ADDC_AM = 5'h04,
    OP_ADDC_MA = 5'h05,
    OP_ADDC_A = 5'h06,
    OP_ADDC_M = 5'h07,
    OP_SUB_AI = 5'h08,
    OP_SUB_AM = 5'h09,
    OP_SUB_MA = 5'h0A,
    OP_SUBC_AM = 5'h0B,
    OP_SUBC_MA = 5'h0C,
    OP_SUBC_A = 5'h0D,
    OP_SUBC_M = 5'h0E,
    OP_INC_M = 5'h0F,
    OP_DEC_M = 5'h10,
    OP_CLR_M = 5'h11
  } bau_op_t;

  // register decode result
  typedef enum logic [2:0] {SEL_ACCUM, SEL_FLAGS, SEL_CMD, SEL_MEM, SEL_NONE} bau_sel_t;

  typedef logic [7:0] bau_byte_t;

endpackage : bau_pkg

// ---- rtl/bau_adder.sv ----
// 8-bit adder with borrow handling and the carry, aux and overflow flags
`timescale 1ns/1ns
`default_nettype none

module bau_adder
  import bau_pkg::*;
(
  // operands
  input wire bau_byte_t x,
  input wire bau_byte_t y,
  input wire logic cin,
  input wire logic sub,
  // result and flags
  output bau_byte_t res,
  output logic carry,
  output logic aux,
  output logic ovf
);

  bau_byte_t y_eff;
  logic c_eff;
  logic [8:0] full;
  logic [4:0] half;

  // subtraction is x + ~y + ~borrow; the carry out is then inverted so that carry means borrow
  always_comb begin
    y_eff = sub ? ~y : y;
    c_eff = sub ? ~cin : cin;
    full = {1'h0, x} + {1'h0, y_eff} + {8'h00, c_eff};
    half = {1'h0, x[3:0]} + {1'h0, y_eff[3:0]} + {4'h0, c_eff};
    res = full[7:0];
    carry = full[8] ^ sub;
    aux = half[4] ^ sub;
    ovf = (x[7] == y_eff[7]) && (full[7] != x[7]);
  end

endmodule : bau_adder

`default_nettype wire

// ---- rtl/bau_top.sv ----
// byte arithmetic unit with accumulator, flags and data bytes behind AXI4-Lite
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "bau_map.svh"

module bau_top
  import bau_pkg::*;
#(
  parameter int MEM_WORDS = 16
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // write address channel
  input wire logic [`BAU_ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  // write data channel
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // write response channel
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // read address channel
  input wire logic [`BAU_ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  // read data channel
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);

  localparam int IDX_W = (MEM_WORDS > 1) ? $clog2(MEM_WORDS) : 1;

  // ****************************************************************
  // decode helpers
  // ****************************************************************

  // word address to register; byte lanes inside a word are not decoded
  function automatic bau_sel_t reg_sel(input logic [`BAU_ADDR_W-1:0] a);
    logic [`BAU_ADDR_W-1:0] wa;
    wa = {a[`BAU_ADDR_W-1:2], 2'h0};
    if (wa == `BAU_OFF_ACCUM) return SEL_ACCUM;
    if (wa == `BAU_OFF_FLAGS) return SEL_FLAGS;
    if (wa == `BAU_OFF_CMD) return SEL_CMD;
    if (wa >= `BAU_OFF_MEM && (wa - `BAU_OFF_MEM) < 8'(4 * MEM_WORDS)) return SEL_MEM;
    return SEL_NONE;
  endfunction : reg_sel

  function automatic logic [IDX_W-1:0] mem_idx(input logic [`BAU_ADDR_W-1:0] a);
    return IDX_W'((a - `BAU_OFF_MEM) >> 2);
  endfunction : mem_idx

  // ****************************************************************
  // architectural state
  // ****************************************************************
  bau_byte_t accumulator;
  logic [3:0] flags;
  logic [23:0] cmd_q;
  bau_byte_t mem [MEM_WORDS];

  // ****************************************************************
  // write channels
  // ****************************************************************
  logic aw_held;
  logic w_held;
  logic [`BAU_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic [`BAU_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  bau_sel_t wr_sel;

  // no new write is taken while a response waits, so one write at a time
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign aw_fire = AWVALID && AWREADY;
  assign w_fire = WVALID && WREADY;
  // write happens at the edge where both halves are present, either order
  assign do_write = (aw_held || aw_fire) && (w_held || w_fire);
  assign wr_addr = aw_held ? aw_addr_q : AWADDR;
  assign wr_data = w_held ? w_data_q : WDATA;
  assign wr_strb = w_held ? w_strb_q : WSTRB;
  assign wr_sel = reg_sel(wr_addr);

  // hold the address half until the data half arrives
  always_ff @(posedge MCLK) begin
    if (RST) begin
      aw_held <= 1'h0;
      aw_addr_q <= '0;
    end else if (do_write) begin
      aw_held <= 1'h0;
    end else if (aw_fire) begin
      aw_held <= 1'h1;
      aw_addr_q <= AWADDR;
    end
  end

  // hold the data half until the address half arrives
  always_ff @(posedge MCLK) begin
    if (RST) begin
      w_held <= 1'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (do_write) begin
      w_held <= 1'h0;
    end else if (w_fire) begin
      w_held <= 1'h1;
      w_data_q <= WDATA;
      w_strb_q <= WSTRB;
    end
  end

  // write response, unmapped addresses answer with a slave error
  always_ff @(posedge MCLK) begin
    if (RST) begin
      BVALID <= 1'h0;
      BRESP <= `BAU_RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'h1;
      BRESP <= (wr_sel == SEL_NONE) ? `BAU_RESP_SLVERR : `BAU_RESP_OKAY;
    end else if (BREADY) begin
      BVALID <= 1'h0;
    end
  end

  // ****************************************************************
  // command decode and operand steering
  // ****************************************************************
  logic [23:0] cmd_m;
  logic exec;
  bau_op_t op;
  logic [IDX_W-1:0] idx;
  bau_byte_t imm;
  bau_byte_t mem_rd;
  bau_byte_t x;
  bau_byte_t y;
  logic cin;
  logic sub;
  logic to_acc;
  logic to_mem;
  logic clr;
  logic upd_flags;
  bau_byte_t res;
  logic res_c;
  logic res_ac;
  logic res_ov;

  // lanes left unstrobed keep the previous command field
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cmd_m[8*i +: 8] = wr_strb[i] ? wr_data[8*i +: 8] : cmd_q[8*i +: 8];
    end
  end

  // an operation runs at the edge that writes the opcode lane
  assign exec = do_write && (wr_sel == SEL_CMD) && wr_strb[0];
  assign op = bau_op_t'(cmd_m[`BAU_CMD_OP_LSB +: 5]);
  assign idx = cmd_m[`BAU_CMD_ADDR_LSB +: IDX_W];
  assign imm = cmd_m[`BAU_CMD_IMM_LSB +: 8];
  assign mem_rd = mem[idx];

  // every form but no-op and clear is one pass through the adder; cin is carry or borrow in
  always_comb begin
    x = accumulator;
    y = 8'h00;
    cin = 1'h0;
    sub = 1'h0;
    to_acc = 1'h0;
    to_mem = 1'h0;
    clr = 1'h0;
    unique case (op)
      OP_NOP: begin
      end
      OP_ADD_AI: begin
        y = imm;
        to_acc = 1'h1;
      end
      OP_ADD_AM: begin
        y = mem_rd;
        to_acc = 1'h1;
      end
      OP_ADD_MA: begin
        y = mem_rd;
        to_mem = 1'h1;
      end
      OP_ADDC_AM: begin
        y = mem_rd;
        cin = flags[`BAU_FLAG_C];
        to_acc = 1'h1;
      end
      OP_ADDC_MA: begin
        y = mem_rd;
        cin = flags[`BAU_FLAG_C];
        to_mem = 1'h1;
      end
      OP_ADDC_A: begin
        cin = flags[`BAU_FLAG_C];
        to_acc = 1'h1;
      end
      OP_ADDC_M: begin
        x = mem_rd;
        cin = flags[`BAU_FLAG_C];
        to_mem = 1'h1;
      end
      OP_SUB_AI: begin
        y = imm;
        sub = 1'h1;
        to_acc = 1'h1;
      end
      OP_SUB_AM: begin
        y = mem_rd;
        sub = 1'h1;
        to_acc = 1'h1;
      end
      OP_SUB_MA: begin
        x = mem_rd;
        y = accumulator;
        sub = 1'h1;
        to_mem = 1'h1;
      end
      OP_SUBC_AM: begin
        y = mem_rd;
        cin = flags[`BAU_FLAG_C];
        sub = 1'h1;
        to_acc = 1'h1;
      end
      OP_SUBC_MA: begin
        x = mem_rd;
        y = accumulator;
        cin = flags[`BAU_FLAG_C];
        sub = 1'h1;
        to_mem = 1'h1;
      end
      OP_SUBC_A: begin
        cin = flags[`BAU_FLAG_C];
        sub = 1'h1;
        to_acc = 1'h1;
      end
      OP_SUBC_M: begin
        x = mem_rd;
        cin = flags[`BAU_FLAG_C];
        sub = 1'h1;
        to_mem = 1'h1;
      end
      OP_INC_M: begin
        x = mem_rd;
        cin = 1'h1;
        to_mem = 1'h1;
      end
      OP_DEC_M: begin
        x = mem_rd;
        cin = 1'h1;
        sub = 1'h1;
        to_mem = 1'h1;
      end
      OP_CLR_M: begin
        clr = 1'h1;
      end
      default: begin
        // unassigned codes behave as no operation
      end
    endcase
  end

  // clear is the only form that writes without touching flags
  assign upd_flags = to_acc || to_mem;

  bau_adder u_adder (
    .x(x),
    .y(y),
    .cin(cin),
    .sub(sub),
    .res(res),
    .carry(res_c),
    .aux(res_ac),
    .ovf(res_ov)
  );

  // ****************************************************************
  // state updates
  // ****************************************************************

  // accumulator: software write or operation result
  always_ff @(posedge MCLK) begin
    if (RST) begin
      accumulator <= `BAU_RST_ACC;
    end else if (exec && to_acc) begin
      accumulator <= res;
    end else if (do_write && wr_sel == SEL_ACCUM && wr_strb[0]) begin
      accumulator <= wr_data[7:0];
    end
  end

  // flags: software may preset carry before a carry form
  always_ff @(posedge MCLK) begin
    if (RST) begin
      flags <= `BAU_RST_FLAGS;
    end else if (exec && upd_flags) begin
      flags[`BAU_FLAG_Z] <= (res == 8'h00);
      flags[`BAU_FLAG_C] <= res_c;
      flags[`BAU_FLAG_AUX] <= res_ac;
      flags[`BAU_FLAG_OVF] <= res_ov;
    end else if (do_write && wr_sel == SEL_FLAGS && wr_strb[0]) begin
      flags <= wr_data[3:0];
    end
  end

  // last command, read back for debug
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cmd_q <= `BAU_RST_CMD;
    end else if (do_write && wr_sel == SEL_CMD) begin
      cmd_q <= cmd_m;
    end
  end

  // data bytes: software write, operation result or clear
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= `BAU_RST_MEM;
      end
    end else if (exec && clr) begin
      mem[idx] <= 8'h00;
    end else if (exec && to_mem) begin
      mem[idx] <= res;
    end else if (do_write && wr_sel == SEL_MEM && wr_strb[0]) begin
      mem[mem_idx(wr_addr)] <= wr_data[7:0];
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  logic [31:0] rd_data;
  logic [1:0] rd_resp;

  assign ARREADY = !RVALID;

  // bits above a register's width read as zero
  always_comb begin
    rd_data = 32'h00000000;
    rd_resp = `BAU_RESP_OKAY;
    unique case (reg_sel(ARADDR))
      SEL_ACCUM: rd_data = {24'h000000, accumulator};
      SEL_FLAGS: rd_data = {28'h0000000, flags};
      SEL_CMD: rd_data = {8'h00, cmd_q};
      SEL_MEM: rd_data = {24'h000000, mem[mem_idx(ARADDR)]};
      SEL_NONE: rd_resp = `BAU_RESP_SLVERR;
    endcase
  end

  // data is registered at the address handshake and held until taken
  always_ff @(posedge MCLK) begin
    if (RST) begin
      RVALID <= 1'h0;
      RDATA <= 32'h00000000;
      RRESP <= `BAU_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'h1;
      RDATA <= rd_data;
      RRESP <= rd_resp;
    end else if (RREADY) begin
      RVALID <= 1'h0;
    end
  end

  // ****************************************************************
  // checks: snapshot of the state just before each operation
  // ****************************************************************
  logic h_valid;
  bau_op_t h_op;
  bau_byte_t h_accum;
  bau_byte_t h_mem;
  bau_byte_t h_imm;
  logic h_c;
  logic h_upd;
  logic h_to_mem;
  logic [IDX_W-1:0] h_idx;
  logic [3:0] h_flags;
  bau_byte_t h_res;

  always_ff @(posedge MCLK) begin
    h_valid <= exec && !RST;
    h_op <= op;
    h_accum <= accumulator;
    h_mem <= mem_rd;
    h_imm <= imm;
    h_c <= flags[`BAU_FLAG_C];
    h_upd <= upd_flags;
    h_to_mem <= to_mem;
    h_idx <= idx;
    h_flags <= flags;
  end

  assign h_res = h_to_mem ? mem[h_idx] : accumulator;

  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);

  chk_add_imm_sum: assert property (h_valid && h_op == OP_ADD_AI |->
    {flags[`BAU_FLAG_C], accumulator} == ({1'h0, h_accum} + {1'h0, h_imm}))
    else $error("add immediate result or carry wrong");
  chk_add_mem_dst: assert property (h_valid && h_op == OP_ADD_MA |->
    mem[h_idx] == 8'(h_accum + h_mem) && accumulator == h_accum)
    else $error("add into memory wrong");
  chk_addc_accum_sum: assert property (h_valid && h_op == OP_ADDC_AM |->
    accumulator == 8'(h_accum + h_mem + {7'h00, h_c}))
    else $error("add with carry into accumulator wrong");
  chk_addc_carry_only: assert property (h_valid && h_op == OP_ADDC_M |->
    mem[h_idx] == 8'(h_mem + {7'h00, h_c}))
    else $error("carry-only add on memory wrong");
  chk_sub_imm_borrow: assert property (h_valid && h_op == OP_SUB_AI |->
    accumulator == 8'(h_accum - h_imm) && flags[`BAU_FLAG_C] == (h_accum < h_imm))
    else $error("subtract immediate result or borrow wrong");
  chk_sub_mem_accum: assert property (h_valid && h_op == OP_SUB_AM |->
    accumulator == 8'(h_accum - h_mem))
    else $error("subtract memory from accumulator wrong");
  chk_sub_accum_mem: assert property (h_valid && h_op == OP_SUB_MA |->
    mem[h_idx] == 8'(h_mem - h_accum) && accumulator == h_accum)
    else $error("subtract accumulator from memory wrong");
  chk_subc_accum_diff: assert property (h_valid && h_op == OP_SUBC_AM |->
    accumulator == 8'(h_accum - h_mem - {7'h00, h_c}))
    else $error("subtract with carry into accumulator wrong");
  chk_subc_mem_diff: assert property (h_valid && h_op == OP_SUBC_MA |->
    mem[h_idx] == 8'(h_mem - h_accum - {7'h00, h_c}))
    else $error("subtract with carry into memory wrong");
  chk_subc_accum_only: assert property (h_valid && h_op == OP_SUBC_A |->
    accumulator == 8'(h_accum - {7'h00, h_c}))
    else $error("carry-only subtract on accumulator wrong");
  chk_subc_mem_only: assert property (h_valid && h_op == OP_SUBC_M |->
    mem[h_idx] == 8'(h_mem - {7'h00, h_c}))
    else $error("carry-only subtract on memory wrong");
  chk_inc_mem_wrap: assert property (h_valid && h_op == OP_INC_M |->
    mem[h_idx] == 8'(h_mem + 8'h01) && flags[`BAU_FLAG_C] == (h_mem == 8'hFF))
    else $error("increment wrong");
  chk_dec_mem_wrap: assert property (h_valid && h_op == OP_DEC_M |->
    mem[h_idx] == 8'(h_mem - 8'h01) && flags[`BAU_FLAG_C] == (h_mem == 8'h00))
    else $error("decrement wrong");
  chk_clear_keeps_flags: assert property (h_valid && h_op == OP_CLR_M |->
    mem[h_idx] == 8'h00 && flags == h_flags)
    else $error("clear changed flags or missed the byte");
  chk_zero_flag_track: assert property (h_valid && h_upd |->
    flags[`BAU_FLAG_Z] == (h_res == 8'h00))
    else $error("zero flag does not follow result");
  chk_aux_nibble_carry: assert property (h_valid && h_op == OP_ADD_AM |->
    flags[`BAU_FLAG_AUX] == (({1'h0, h_accum[3:0]} + {1'h0, h_mem[3:0]}) >= 5'h10))
    else $error("aux carry on add wrong");
  chk_ovf_signed_add: assert property (h_valid && h_op == OP_ADD_AI |->
    flags[`BAU_FLAG_OVF] == ((h_accum[7] == h_imm[7]) && (accumulator[7] != h_accum[7])))
    else $error("overflow on add wrong");

endmodule : bau_top

`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the byte arithmetic unit over its register bus
`timescale 1ns/1ns
`default_nettype none
`include "bau_map.svh"

module tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0] AWADDR, ARADDR;
  logic [2:0] AWPROT, ARPROT;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  int num_errors = 0;
  int checks_done = 0;
  // operand sets {acc, mem, imm, carry}: overflow, zero, nibble carry, wrap
  localparam logic [31:0] VEC [4] = '{32'h7F018001, 32'h00000000, 32'hF8080F01,
    32'h80FFFF00};

  bau_top u_bau_top (.MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWPROT(AWPROT),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(ARPROT), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY));

  // free-running clock, 10 ns period
  initial begin
    MCLK = 0;
    forever #5 MCLK = ~MCLK;
  end

  // ****************************************************************
  // bus and comparison tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // both halves offered together; each released at its own take
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    logic aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    AWADDR <= ad;
    WDATA <= d;
    AWVALID <= 1;
    WVALID <= 1;
    do begin
      @(posedge MCLK);
      n++;
      if (!aw && AWREADY) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 0;
      end
    end while (!(aw && w) && n < 50);
    // bready stays high, so the answer is taken where it is seen
    do begin
      @(posedge MCLK);
      n++;
    end while (!BVALID && n < 100);
    rs = BRESP;
    if (n >= 100) num_errors++;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    ARADDR <= ad;
    ARVALID <= 1;
    do begin
      @(posedge MCLK);
      n++;
    end while (!ARREADY && n < 50);
    ARVALID <= 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (!RVALID && n < 100);
    d = RDATA;
    rs = RRESP;
    if (n >= 100) num_errors++;
  endtask : rd

  // ****************************************************************
  // reference arithmetic: {result, overflow, aux, carry, zero}
  // ****************************************************************
  function automatic logic [11:0] model(input logic [4:0] op, input logic [7:0] a,
    input logic [7:0] m, input logic [7:0] i, input logic c);
    logic [7:0] x;
    logic [7:0] y;
    logic ci;
    logic s;
    logic [8:0] r;
    logic [4:0] nb;
    logic ov;
    s = 0;
    x = a;
    y = m;
    ci = 0;
    case (op)
      5'h01: y = i;
      5'h04, 5'h05: ci = c;
      5'h06: begin y = 0; ci = c; end
      5'h07: begin x = m; y = 0; ci = c; end
      5'h08: begin y = i; s = 1; end
      5'h09: s = 1;
      5'h0A: begin x = m; y = a; s = 1; end
      5'h0B: begin s = 1; ci = c; end
      5'h0C: begin x = m; y = a; s = 1; ci = c; end
      5'h0D: begin y = 0; s = 1; ci = c; end
      5'h0E: begin x = m; y = 0; s = 1; ci = c; end
      5'h0F: begin x = m; y = 0; ci = 1; end
      5'h10: begin x = m; y = 0; s = 1; ci = 1; end
      default: ;
    endcase
    // subtraction borrows out of bit 8, so carry means borrow there
    r = s ? {1'b0, x} - y - ci : {1'b0, x} + y + ci;
    nb = s ? {1'b0, x[3:0]} - y[3:0] - ci : {1'b0, x[3:0]} + y[3:0] + ci;
    ov = (s ? x[7] != y[7] : x[7] == y[7]) && (r[7] != x[7]);
    return {r[7:0], ov, nb[4], r[8], r[7:0] == 8'h00};
  endfunction : model

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // accumulator, flags and the first data byte read zero after reset
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] rs;
    rd(`BAU_OFF_ACCUM, d, rs);
    chk(d, 32'h0);
    rd(`BAU_OFF_FLAGS, d, rs);
    chk(d, 32'h0);
    rd(`BAU_OFF_MEM, d, rs);
    chk(d, 32'h0);
  endtask : t_reset

  // opcodes 1 to 16 (add through decrement) on every operand set, destination and flags checked
  task automatic t_ops();
    logic [7:0] a, m, i, ad;
    logic c, dm;
    logic [11:0] e;
    logic [31:0] d;
    logic [1:0] rs;
    for (int v = 0; v < 4; v++) begin
      for (int op = 1; op < 17; op++) begin
        {a, m, i} = VEC[v][31:8];
        c = VEC[v][0];
        ad = 8'h40 + {2'h0, op[3:0], 2'h0};
        e = model(op[4:0], a, m, i, c);
        dm = op[4:0] inside {5'h03, 5'h05, 5'h07, 5'h0A, 5'h0C, 5'h0E, 5'h0F, 5'h10};
        wr(`BAU_OFF_ACCUM, {24'h0, a}, rs);
        wr(`BAU_OFF_FLAGS, {30'h0, c, 1'b0}, rs);
        wr(ad, {24'h0, m}, rs);
        wr(`BAU_OFF_CMD, {8'h00, i, 4'h0, op[3:0], 3'h0, op[4:0]}, rs);
        chk({30'h0, rs}, 32'h0);
        rd(`BAU_OFF_ACCUM, d, rs);
        chk(d, {24'h0, dm ? a : e[11:4]});
        rd(ad, d, rs);
        chk(d, {24'h0, dm ? e[11:4] : m});
        rd(`BAU_OFF_FLAGS, d, rs);
        chk(d, {28'h0, e[3:0]});
      end
    end
  endtask : t_ops

  // clearing a byte must not disturb any preset flag
  task automatic t_clear();
    logic [31:0] d;
    logic [1:0] rs;
    wr(`BAU_OFF_FLAGS, 32'h0000000F, rs);
    wr(8'h54, 32'h0000003C, rs);
    wr(`BAU_OFF_CMD, 32'h00000511, rs);
    rd(8'h54, d, rs);
    chk(d, 32'h0);
    rd(`BAU_OFF_FLAGS, d, rs);
    chk(d, 32'h0000000F);
    rd(`BAU_OFF_CMD, d, rs);
    chk(d, 32'h00000511);
  endtask : t_clear

  // unmapped offsets answer with an error and read as zero
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] rs;
    wr(8'h80, 32'hFFFFFFFF, rs);
    chk({30'h0, rs}, {30'h0, `BAU_RESP_SLVERR});
    rd(8'h0C, d, rs);
    chk(d, 32'h0);
    chk({30'h0, rs}, {30'h0, `BAU_RESP_SLVERR});
  endtask : t_unmapped

  // ****************************************************************
  // verdict, main sequence and watchdog
  // ****************************************************************
  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // main sequence; ready inputs stay high so answers are taken at once
  initial begin
    RST = 1;
    AWADDR = 0;
    AWPROT = 0;
    AWVALID = 0;
    WDATA = 0;
    WSTRB = 4'hF;
    WVALID = 0;
    BREADY = 1;
    ARADDR = 0;
    ARPROT = 0;
    ARVALID = 0;
    RREADY = 1;
    repeat (8) @(posedge MCLK);
    RST <= 0;
    @(posedge MCLK);
    t_reset();
    t_ops();
    t_clear();
    t_unmapped();
    give_verdict();
  end

  // run needs about 1000 cycles; cut a hang well beyond that
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
